// *** spsd_pkg.sv ***
/*
 * Package for the serial port status and data path: register offsets, field
 * positions, reset values, state codes and the master clock divider table.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package spsd_pkg;

   // register offsets on the plain register port
   localparam logic [7:0] ADDR_DATA    = 8'h31;
   localparam logic [7:0] ADDR_CTRL    = 8'h32;
   localparam logic [7:0] ADDR_CSR     = 8'h33;
   localparam logic [7:0] ADDR_EVT     = 8'h38;
   localparam logic [7:0] ADDR_EVT_EN  = 8'h39;
   localparam logic [7:0] ADDR_EVT_CLR = 8'h3a;

   // serial_control fields
   localparam int CTRL_IE   = 7;
   localparam int CTRL_EN   = 6;
   localparam int CTRL_SPR2 = 5;
   localparam int CTRL_MSTR = 4;
   localparam int CTRL_CPOL = 3;
   localparam int CTRL_CPHA = 2;
   localparam int CTRL_SPR1 = 1;
   localparam int CTRL_SPR0 = 0;

   // serial_control_status fields
   localparam int CSR_DONE = 7;
   localparam int CSR_WRITE_COLLISION_FLAG = 6;
   localparam int CSR_OVR  = 5;
   localparam int CSR_MASTER_FAULT_FLAG = 4;
   localparam int CSR_RSVD = 3;
   localparam int CSR_SOD  = 2;
   localparam int CSR_SSM  = 1;
   localparam int CSR_SSI  = 0;

   // event register fields
   localparam int EV_DONE = 0;
   localparam int EV_OVR  = 1;
   localparam int EV_MASTER_FAULT_FLAG = 2;
   localparam int EV_WRITE_COLLISION_FLAG = 3;

   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [2:0] CFG_RST    = 3'h0;
   localparam logic [3:0] EVT_RST    = 4'h0;
   localparam logic [7:0] DATA_RST   = 8'h00;
   localparam logic [3:0] LAST_BIT   = 4'h7;
   localparam logic [4:0] LAST_EDGE  = 5'h0f;
   // longest master byte: 16 edges at the slowest half period
   localparam logic [10:0] RUN_MAX   = 11'h400;

   // half periods of the master clock, in system clocks
   localparam logic [6:0] HALF_DIV4   = 7'h02;
   localparam logic [6:0] HALF_DIV8   = 7'h04;
   localparam logic [6:0] HALF_DIV16  = 7'h08;
   localparam logic [6:0] HALF_DIV32  = 7'h10;
   localparam logic [6:0] HALF_DIV64  = 7'h20;
   localparam logic [6:0] HALF_DIV128 = 7'h40;

   typedef enum logic [1:0] {
      SPSD_IDLE = 2'b01,
      SPSD_RUN  = 2'b10
   } spsd_state_t;

   // rate select {spr2, spr1, spr0}; unlisted codes take the slowest
   function automatic logic [6:0] spsd_half(input logic [2:0] sel);
      case (sel)
         3'h4:    spsd_half = HALF_DIV4;
         3'h0:    spsd_half = HALF_DIV8;
         3'h1:    spsd_half = HALF_DIV16;
         3'h6:    spsd_half = HALF_DIV32;
         3'h2:    spsd_half = HALF_DIV64;
         default: spsd_half = HALF_DIV128;
      endcase
   endfunction : spsd_half

endpackage : spsd_pkg

`default_nettype wire

// *** spsd_port.sv ***
/*
 * Byte-wide synchronous serial port: status flags and their clearing
 * sequences, select management, output disable, shift register, receive
 * buffer, register port and interrupt.
 * Assumes one system clock, a register master that never waits, and serial
 * pins that arrive unsynchronised (the serial clock is sampled, not used).
 */
// Behaviour
// - transfer end sets done flag, may interrupt
// - done clears: status access then data access
// - data writes ignored while done, unread status
// - data write mid-transfer sets write collision
// - byte arriving while done set flags overrun
// - status read clears overrun flag
// - master with select low sets fault
// - fault clears: status access then control write
// - output disable drops serial data output
// - software management ignores external select pin
// - internal select level zero means selected
// - master data write starts one byte
// - received byte buffered; reads return buffer
// - data write loads shift register directly
// - data, control, status at 31h, 32h, 33h
// - one interrupt: enable and done, overrun or fault flag, or any event bit set with its enable bit set
`timescale 1ns/100ps
`default_nettype none

module spsd_port
   import spsd_pkg::*;
(
   input  wire logic       sys_clk,    // system clock, 20 MHz
   input  wire logic       nrst,       // asynchronous reset, active low
   input  wire logic [7:0] reg_addr,   // register address
   input  wire logic [7:0] reg_wdata,  // register write data
   input  wire logic       reg_wr,     // write strobe
   input  wire logic       reg_rd,     // read strobe
   output logic      [7:0] reg_rdata,  // read data, cycle after strobe
   input  wire logic       sck_in,     // serial clock pin level
   output logic            sck_out,    // serial clock drive level
   output logic            sck_oe,     // serial clock drive enable
   input  wire logic       mosi_in,    // master-out pin level
   output logic            mosi_out,   // master-out drive level
   output logic            mosi_oe,    // master-out drive enable
   input  wire logic       miso_in,    // master-in pin level
   output logic            miso_out,   // master-in drive level
   output logic            miso_oe,    // master-in drive enable
   input  wire logic       ss_n_in,    // slave select pin, active low
   output logic            irq         // level interrupt
);

   logic [3:0]  sync1;
   logic [3:0]  sync2;
   logic        sck_d;
   logic [7:0]  ctrl;
   logic [2:0]  cfg;
   logic        transfer_done_flag;
   logic        write_collision_flag;
   logic        overrun_flag;
   logic        master_fault_flag;
   logic        stat_acc;
   logic        stat_rd;
   logic        master_fault_flag_arm;
   logic [7:0]  shreg;
   logic [7:0]  rx_buf;
   logic        out_bit;
   logic [3:0]  bit_cnt;
   logic [6:0]  div_cnt;
   logic [4:0]  edge_cnt;
   logic [10:0] run_cyc;
   logic        sck_lvl;
   spsd_state_t state;
   spsd_state_t next_state;
   logic [3:0]  evt;
   logic [3:0]  evt_en;
   logic [7:0]  next_rdata;

   // synchronised pins: sck, mosi, miso, select
   wire sck_s  = sync2[3];
   wire mosi_s = sync2[2];
   wire miso_s = sync2[1];
   wire ss_s   = sync2[0];

   // register decode
   wire wr_data = reg_wr & (reg_addr == ADDR_DATA);
   wire rd_data = reg_rd & (reg_addr == ADDR_DATA);
   wire wr_ctrl = reg_wr & (reg_addr == ADDR_CTRL);
   wire wr_csr  = reg_wr & (reg_addr == ADDR_CSR);
   wire rd_csr  = reg_rd & (reg_addr == ADDR_CSR);
   wire wr_een  = reg_wr & (reg_addr == ADDR_EVT_EN);
   wire wr_eclr = reg_wr & (reg_addr == ADDR_EVT_CLR);
   wire csr_acc = wr_csr | rd_csr;
   wire dat_acc = wr_data | rd_data;

   wire enabled = ctrl[CTRL_EN];
   wire master  = ctrl[CTRL_MSTR];
   wire cpol    = ctrl[CTRL_CPOL];
   wire cpha    = ctrl[CTRL_CPHA];
   wire run     = (state == SPSD_RUN);

   // pin ignored under software management
   wire ss_int   = cfg[CSR_SSM] ? cfg[CSR_SSI] : ss_s;
   wire slv_sel  = enabled & ~master & ~ss_int;
   wire master_fault_flag_set = enabled & master & ~ss_int;

   // master clock generation
   wire [6:0] half   = spsd_half({ctrl[CTRL_SPR2], ctrl[CTRL_SPR1], ctrl[CTRL_SPR0]});
   wire       m_tick = run & (div_cnt == half - 7'h01);
   wire       m_lead = ~edge_cnt[0];
   wire       m_last = m_tick & (edge_cnt == LAST_EDGE);

   // slave edges of the sampled clock
   wire s_lead = slv_sel & (sck_d == cpol) & (sck_s != cpol);
   wire s_trl  = slv_sel & (sck_d != cpol) & (sck_s == cpol);

   wire lead_e = master ? (m_tick & m_lead) : s_lead;
   wire trl_e  = master ? (m_tick & ~m_lead) : s_trl;
   wire sample = cpha ? trl_e : lead_e;
   wire drive  = cpha ? lead_e : trl_e;
   wire rx_in  = master ? miso_s : mosi_s;

   wire [7:0] shreg_in = {shreg[6:0], rx_in};
   wire [7:0] shreg_nx = sample ? shreg_in : shreg;
   wire       s_last   = ~master & sample & (bit_cnt == LAST_BIT);
   wire       done     = master ? m_last : s_last;
   wire       busy     = run | (bit_cnt != 4'h0);

   // a write is dropped while done is set and status is unread
   wire wr_block = transfer_done_flag & ~stat_rd;
   wire write_collision_flag_set = wr_data & busy;
   wire load     = wr_data & ~wr_block & ~busy;
   wire start    = load & master & enabled;
   wire ovr_set  = done & transfer_done_flag;

   wire [3:0] ev_set = {write_collision_flag_set, master_fault_flag_set, ovr_set, done};
   wire       port_irq = ctrl[CTRL_IE] & (transfer_done_flag | master_fault_flag | overrun_flag);
   wire       next_irq = port_irq | (|(evt & evt_en));
   wire       output_disable      = cfg[CSR_SOD];

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
         sck_d <= 1'b0;
      end else begin
         sync1 <= {sck_in, mosi_in, miso_in, ss_n_in};
         sync2 <= sync1;
         sck_d <= sync2[3];
      end
   end

   // master sequencer
   always_comb begin
      next_state = state;
      case (state)
         SPSD_IDLE: if (start) next_state = SPSD_RUN;
         SPSD_RUN: begin
            if (m_last | ~enabled | ~master) next_state = SPSD_IDLE;
         end
         default: next_state = SPSD_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state    <= SPSD_IDLE;
         run_cyc  <= 11'h000;
         div_cnt  <= 7'h00;
         edge_cnt <= 5'h00;
         sck_lvl  <= 1'b0;
      end else begin
         state <= next_state;
         // whole-byte length, so a stuck divider cannot hide
         run_cyc <= run ? run_cyc + 11'h001 : 11'h000;
         if (!run) begin
            div_cnt  <= 7'h00;
            edge_cnt <= 5'h00;
            sck_lvl  <= cpol;
         end else if (m_tick) begin
            div_cnt  <= 7'h00;
            edge_cnt <= edge_cnt + 5'h01;
            sck_lvl  <= ~sck_lvl;
         end else begin
            div_cnt <= div_cnt + 7'h01;
         end
      end
   end

   // shift register and receive buffer
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         shreg   <= DATA_RST;
         rx_buf  <= DATA_RST;
         out_bit <= 1'b0;
         bit_cnt <= 4'h0;
      end else begin
         if (load) begin
            shreg   <= reg_wdata;
            out_bit <= reg_wdata[7];
         end else begin
            shreg <= shreg_nx;
            if (drive) out_bit <= shreg[7];
         end
         // overrun keeps the older byte; the new one is lost
         if (done & ~transfer_done_flag) rx_buf <= shreg_nx;
         // deselect mid-byte restarts bit counting
         if (done | (~master & ~slv_sel) | (master & ~run)) bit_cnt <= 4'h0;
         else if (sample) bit_cnt <= bit_cnt + 4'h1;
      end
   end

   // flags; hardware set beats software clear in the same cycle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         transfer_done_flag     <= 1'b0;
         write_collision_flag     <= 1'b0;
         overrun_flag      <= 1'b0;
         master_fault_flag     <= 1'b0;
         stat_acc <= 1'b0;
         stat_rd  <= 1'b0;
         master_fault_flag_arm <= 1'b0;
      end else begin
         if (done) transfer_done_flag <= 1'b1;
         else if (dat_acc & stat_acc) transfer_done_flag <= 1'b0;
         if (write_collision_flag_set) write_collision_flag <= 1'b1;
         else if (dat_acc & stat_rd) write_collision_flag <= 1'b0;
         if (ovr_set) overrun_flag <= 1'b1;
         else if (rd_csr) overrun_flag <= 1'b0;
         if (master_fault_flag_set) master_fault_flag <= 1'b1;
         else if (wr_ctrl & master_fault_flag_arm) master_fault_flag <= 1'b0;
         if (dat_acc) stat_acc <= 1'b0;
         else if (csr_acc) stat_acc <= 1'b1;
         if (dat_acc) stat_rd <= 1'b0;
         else if (rd_csr) stat_rd <= 1'b1;
         if (wr_ctrl) master_fault_flag_arm <= 1'b0;
         else if (csr_acc & master_fault_flag) master_fault_flag_arm <= 1'b1;
      end
   end

   // configuration and interrupt registers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl   <= CTRL_RST;
         cfg    <= CFG_RST;
         evt    <= EVT_RST;
         evt_en <= EVT_RST;
      end else begin
         if (master_fault_flag_set) begin
            ctrl[CTRL_EN]   <= 1'b0;
            ctrl[CTRL_MSTR] <= 1'b0;
            if (wr_ctrl) begin
               ctrl[CTRL_IE]   <= reg_wdata[CTRL_IE];
               ctrl[CTRL_SPR2] <= reg_wdata[CTRL_SPR2];
               ctrl[3:0]       <= reg_wdata[3:0];
            end
         end else if (wr_ctrl) begin
            ctrl <= reg_wdata;
         end
         // reserved bit 3 is not stored
         if (wr_csr) cfg <= reg_wdata[2:0];
         if (wr_een) evt_en <= reg_wdata[3:0];
         evt <= (evt & ~(wr_eclr ? reg_wdata[3:0] : 4'h0)) | ev_set;
      end
   end

   // read mux
   always_comb begin
      case (reg_addr)
         ADDR_DATA: next_rdata = rx_buf;
         ADDR_CTRL: next_rdata = ctrl;
         ADDR_CSR:  next_rdata = {transfer_done_flag, write_collision_flag, overrun_flag, master_fault_flag, 1'b0, cfg};
         ADDR_EVT:  next_rdata = {4'h0, evt};
         ADDR_EVT_EN: next_rdata = {4'h0, evt_en};
         default:   next_rdata = 8'h00;
      endcase
   end

   // pin drivers, all from flops
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
         sck_out   <= 1'b0;
         sck_oe    <= 1'b0;
         mosi_out  <= 1'b0;
         mosi_oe   <= 1'b0;
         miso_out  <= 1'b0;
         miso_oe   <= 1'b0;
         irq       <= 1'b0;
      end else begin
         reg_rdata <= reg_rd ? next_rdata : 8'h00;
         sck_out   <= run ? sck_lvl : cpol;
         sck_oe    <= enabled & master;
         mosi_out  <= out_bit;
         mosi_oe   <= enabled & master & ~output_disable;
         miso_out  <= out_bit;
         miso_oe   <= slv_sel & ~output_disable;
         irq       <= next_irq;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   property p_done_sets;
      done |=> transfer_done_flag ##1 (transfer_done_flag || $past(dat_acc));
   endproperty
   a_done_sets: assert property (p_done_sets) else $error("done flag not set");

   property p_done_clear;
      (transfer_done_flag && !done && dat_acc && stat_acc) |=> !transfer_done_flag;
   endproperty
   a_done_clear: assert property (p_done_clear) else $error("done flag not cleared");

   property p_wr_inhibit;
      (wr_data && transfer_done_flag && !stat_rd) |=> $stable(rx_buf) && !run && shreg == $past(shreg_nx);
   endproperty
   a_wr_inhibit: assert property (p_wr_inhibit) else $error("blocked write taken");

   property p_write_collision_flag;
      (wr_data && busy) |-> !load ##1 write_collision_flag;
   endproperty
   a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");

   property p_ovr;
      (done && transfer_done_flag) |=> overrun_flag && $stable(rx_buf);
   endproperty
   a_ovr: assert property (p_ovr) else $error("overrun mishandled");

   property p_ovr_clear;
      (rd_csr && !ovr_set) |=> !overrun_flag;
   endproperty
   a_ovr_clear: assert property (p_ovr_clear) else $error("overrun not cleared");

   property p_master_fault_flag;
      master_fault_flag_set |=> master_fault_flag && !ctrl[CTRL_MSTR] && !ctrl[CTRL_EN] ##1 !sck_oe;
   endproperty
   a_master_fault_flag: assert property (p_master_fault_flag) else $error("fault not handled");

   property p_sod;
      output_disable |=> !mosi_oe && !miso_oe;
   endproperty
   a_sod: assert property (p_sod) else $error("output not disabled");

   property p_rx_read;
      rd_data |=> reg_rdata == $past(rx_buf);
   endproperty
   a_rx_read: assert property (p_rx_read) else $error("data read not buffer");

   property p_rsvd;
      rd_csr |=> !reg_rdata[CSR_RSVD];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

   property p_master_run;
      start |=> run;
   endproperty
   a_master_run: assert property (p_master_run) else $error("master byte not started");

   // a rate change mid-byte can break this bound
   property p_run_bound;
      run |-> run_cyc < RUN_MAX;
   endproperty
   a_run_bound: assert property (p_run_bound) else $error("master byte stalled");

   property p_irq;
      (ctrl[CTRL_IE] && (transfer_done_flag || overrun_flag || master_fault_flag)) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missing");

   c_master_done: cover property (master && done);
   c_slave_done: cover property (!master && done);
   c_overrun: cover property (ovr_set);
   c_fault: cover property (master_fault_flag_set);

endmodule : spsd_port

`default_nettype wire

// *** spsd_slave_model.sv ***
/*
 * Partner at the far side of the serial port: a slave that shifts its
 * byte out MSB first and keeps the last whole byte it took in.
 * Assumes clock polarity 0, phase 0, and a select driven by the bench.
 */
`timescale 1ns/100ps
`default_nettype none

module spsd_slave_model (
   input  wire logic       sck,    // serial clock pin
   input  wire logic       sel_n,  // select, active low
   input  wire logic       mosi,   // data from master
   input  wire logic [7:0] tx,     // byte to send back
   output logic            miso,   // data to master
   output logic      [7:0] rx      // last whole byte taken
);
   logic [2:0] cnt = 3'h0;
   logic [7:0] sh  = 8'h00;

   initial begin
      rx = 8'h00;
   end

   // released line shows the inverse, never a stale copy
   assign miso = sel_n ? ~tx[0] : tx[3'h7 - cnt];

   always @(posedge sck) begin
      if (!sel_n) begin
         sh <= {sh[6:0], mosi};
         if (cnt == 3'h7) begin
            rx <= {sh[6:0], mosi};
         end
      end
   end

   always @(negedge sck or posedge sel_n) begin
      if (sel_n) begin
         cnt <= 3'h0;
      end else begin
         cnt <= cnt + 3'h1;
      end
   end
endmodule : spsd_slave_model

`default_nettype wire

// *** spi_status_and_data_path_test.sv ***
/*
 * Self-checking bench for the serial port: register map, master and
 * slave transfers, flag clearing sequences, select handling, interrupt.
 * Assumes spsd_port, spsd_pkg and the slave partner model.
 */
`timescale 1ns/100ps
`default_nettype none

module spi_status_and_data_path_test
   import spsd_pkg::*;
;
   logic       sys_clk    = 1'b0;
   logic       nrst       = 1'b0;
   logic       reg_wr     = 1'b0;
   logic       reg_rd     = 1'b0;
   logic [7:0] reg_addr   = 8'h00;
   logic [7:0] reg_wdata  = 8'h00;
   logic       tb_sck     = 1'b0;
   logic       tb_mosi    = 1'b0;
   logic       tb_ss_n    = 1'b1;
   logic       part_sel_n = 1'b0;
   logic [7:0] part_tx    = 8'h00;
   logic [7:0] slv_out    = 8'h00;
   logic [7:0] reg_rdata, part_rx;
   logic       sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, irq;
   logic       part_miso, sck_pin, mosi_pin, miso_pin;
   int         err_count  = 0;
   int         tests_run  = 0;
   int         cyc        = 0;

   always #25 sys_clk = ~sys_clk;

   assign sck_pin  = sck_oe ? sck_out : tb_sck;
   assign mosi_pin = mosi_oe ? mosi_out : tb_mosi;
   assign miso_pin = miso_oe ? miso_out : part_miso;

   spsd_port u_dut (
      .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sck_in(sck_pin),
      .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_pin), .mosi_out(mosi_out),
      .mosi_oe(mosi_oe), .miso_in(miso_pin), .miso_out(miso_out), .miso_oe(miso_oe),
      .ss_n_in(tb_ss_n), .irq(irq)
   );

   spsd_slave_model u_part (
      .sck(sck_pin), .sel_n(part_sel_n), .mosi(mosi_pin), .tx(part_tx),
      .miso(part_miso), .rx(part_rx)
   );

   task automatic finish_test;
      if (err_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask : chk

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(name, exp, reg_rdata);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // pin read after the wait, not when the call is made
   task automatic pin(input string name, input logic exp);
      logic got;
      repeat (3) @(posedge sys_clk);
      #1;
      case (name)
         "miso_oe": got = miso_oe;
         "mosi_oe": got = mosi_oe;
         "sck_oe":  got = sck_oe;
         default:   got = irq;
      endcase
      chk(name, {7'h00, exp}, {7'h00, got});
   endtask : pin

   task automatic wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
      chk("irq", 8'h01, {7'h00, irq});
   endtask : wait_irq

   // 400 ns link period; clock rests low between bytes
   task automatic slave_byte(input logic [7:0] b);
      // miso taken late in the high phase, past the sync delay
      for (int i = 7; i >= 0; i--) begin
         repeat (4) @(posedge sys_clk);
         slv_out = {slv_out[6:0], miso_pin};
         tb_sck  <= 1'b0;
         tb_mosi <= b[i];
         repeat (4) @(posedge sys_clk);
         tb_sck <= 1'b1;
      end
      repeat (4) @(posedge sys_clk);
      slv_out = {slv_out[6:0], miso_pin};
      tb_sck  <= 1'b0;
      tb_mosi <= ~b[0];
   endtask : slave_byte

   task automatic t_map;
      rd(ADDR_DATA, 8'h00, "data");
      rd(ADDR_CTRL, 8'h00, "ctrl");
      rd(ADDR_CSR, 8'h00, "status");
      wr(8'h30, 8'h5a);
      rd(8'h30, 8'h00, "unmapped");
      wr(ADDR_CSR, 8'hff);
      rd(ADDR_CSR, 8'h07, "status wr");
      wr(ADDR_CSR, 8'h00);
   endtask : t_map

   task automatic t_master;
      part_tx = 8'h3c;
      wr(ADDR_CTRL, 8'hd0);
      wr(ADDR_DATA, 8'ha5);
      wait_irq;
      chk("far rx", 8'ha5, part_rx);
      rd(ADDR_CSR, 8'h80, "status");
      rd(ADDR_DATA, 8'h3c, "rx buf");
      rd(ADDR_CSR, 8'h00, "status");
      chk("irq", 8'h00, {7'h00, irq});
   endtask : t_master

   task automatic t_collide;
      part_tx = 8'hc3;
      wr(ADDR_CTRL, 8'hd1);
      wr(ADDR_DATA, 8'h11);
      wr(ADDR_DATA, 8'h22);
      wait_irq;
      rd(ADDR_CSR, 8'hc0, "status");
      chk("far rx", 8'h11, part_rx);
      rd(ADDR_DATA, 8'hc3, "rx buf");
      rd(ADDR_CSR, 8'h00, "status");
   endtask : t_collide

   task automatic t_inhibit;
      part_tx = 8'h77;
      wr(ADDR_DATA, 8'h0f);
      wait_irq;
      wr(ADDR_DATA, 8'h55);
      repeat (150) @(posedge sys_clk);
      chk("far rx", 8'h0f, part_rx);
      rd(ADDR_CSR, 8'h80, "status");
      wr(ADDR_DATA, 8'h5a);
      repeat (3) @(posedge sys_clk);
      wait_irq;
      chk("far rx", 8'h5a, part_rx);
      rd(ADDR_CSR, 8'h80, "status");
      rd(ADDR_DATA, 8'h77, "rx buf");
      rd(ADDR_CSR, 8'h00, "status");
   endtask : t_inhibit

   task automatic t_slave;
      part_sel_n = 1'b1;
      // slave first, select after: a selected master would fault
      wr(ADDR_CTRL, 8'hc0);
      wr(ADDR_CSR, 8'h02);
      pin("miso_oe", 1'b1);
      wr(ADDR_DATA, 8'h4b);
      slave_byte(8'h96);
      chk("slave out", 8'h4b, slv_out);
      wait_irq;
      rd(ADDR_CSR, 8'h82, "status");
      slave_byte(8'h69);
      repeat (10) @(posedge sys_clk);
      rd(ADDR_CSR, 8'ha2, "status");
      rd(ADDR_DATA, 8'h96, "rx buf");
      rd(ADDR_CSR, 8'h02, "status");
      wr(ADDR_CSR, 8'h06);
      pin("miso_oe", 1'b0);
      wr(ADDR_CSR, 8'h03);
      pin("miso_oe", 1'b0);
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_CSR, 8'h00);
      part_sel_n = 1'b0;
   endtask : t_slave

   task automatic t_fault;
      wr(ADDR_CTRL, 8'hd0);
      pin("mosi_oe", 1'b1);
      pin("sck_oe", 1'b1);
      wr(ADDR_CSR, 8'h04);
      pin("mosi_oe", 1'b0);
      wr(ADDR_CSR, 8'h00);
      wr(ADDR_EVT_CLR, 8'h0f);
      tb_ss_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk("irq", 8'h01, {7'h00, irq});
      tb_ss_n <= 1'b1;
      rd(ADDR_CTRL, 8'h80, "ctrl");
      pin("sck_oe", 1'b0);
      wr(ADDR_CTRL, 8'h00);
      rd(ADDR_CSR, 8'h10, "status");
      wr(ADDR_CTRL, 8'h00);
      rd(ADDR_CSR, 8'h00, "status");
      chk("irq", 8'h00, {7'h00, irq});
      rd(ADDR_EVT, 8'h04, "events");
      wr(ADDR_EVT_EN, 8'h04);
      pin("irq", 1'b1);
      wr(ADDR_EVT_CLR, 8'h04);
      pin("irq", 1'b0);
      rd(ADDR_EVT, 8'h00, "events");
   endtask : t_fault

   // hang guard: whole run needs about 1000 cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         finish_test;
      end
   end

   initial begin
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      t_map;
      t_master;
      t_collide;
      t_inhibit;
      t_slave;
      t_fault;
      finish_test;
   end
endmodule : spi_status_and_data_path_test

`default_nettype wire
